// ### include/isrc_pkg.sv
// Package: register map, field layout and reset values for the
// identity and timing reference configuration bank.
// Assumes byte-wide registers behind a 15-bit serial address.
`default_nettype none
package isrc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [14:0] OFS_CONFIG = 15'h0000;
   localparam logic [14:0] OFS_CLASS = 15'h0003;
   localparam logic [14:0] OFS_FAMILY = 15'h0004;
   localparam logic [14:0] OFS_MAKER = 15'h000c;
   localparam logic [14:0] OFS_USER = 15'h0010;
   localparam logic [14:0] OFS_REFCTL = 15'h0029;
   localparam logic [14:0] OFS_REFPOS = 15'h002c;
   localparam logic [14:0] ADDR_ONE = 15'h0001;
   localparam logic [14:0] ADDR_TWO = 15'h0002;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int ASCEND_BIT = 5;
   localparam int SDO_ACTIVE_BIT = 4;
   localparam int HOLD_BIT = 0;
   localparam int PROC_EN_BIT = 6;
   localparam int RECV_EN_BIT = 5;
   localparam int ZOOM_BIT = 4;
   localparam int SEL_MSB = 3;
   localparam logic [7:0] CONFIG_RESET = 8'h20;
   localparam logic [7:0] CONFIG_MASK = 8'h6f;
   localparam logic [7:0] SDO_ACTIVE_VAL = 8'h10;
   localparam logic [7:0] USER_RESET = 8'h00;
   localparam logic [7:0] REFCTL_RESET = 8'h00;
   localparam logic [3:0] CLASS_RES_RESET = 4'h0;
   localparam logic [3:0] SEL_AUTO = 4'h0;
   // ----------------------------------------
   // Identity values (arbitrary, neutral)
   // ----------------------------------------
   localparam logic [3:0] CLASS_CODE = 4'ha;
   localparam logic [15:0] FAMILY_CODE = 16'h5a17;
   localparam logic [15:0] MAKER_CODE = 16'h0bcd;
   // ----------------------------------------
   // Serial frame layout
   // ----------------------------------------
   localparam logic [4:0] INSTR_LAST = 5'h17;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   typedef enum logic [1:0] {
      ST_INSTR = 2'b01,
      ST_DATA = 2'b10
   } isrc_phase_t;
endpackage
`default_nettype wire

// ### include/isrc_reg_if.sv
// Interface: register access port between the serial engine and
// the register bank. Everything here lives on the serial clock.
`default_nettype none
interface isrc_reg_if;
   logic [14:0] addr;
   logic wr_en;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hold;
   logic ascend;
   modport engine (output addr, output wr_en, output wdata,
                   input rdata, input hold, input ascend);
   modport bank (input addr, input wr_en, input wdata,
                 output rdata, output hold, output ascend);
endinterface
`default_nettype wire

// ### design/isrc_serial_engine.sv
// Serial engine: 24-bit instruction then streamed data bytes.
// Assumes chip select high clears the frame; data out on falling edge.
`default_nettype none
module isrc_serial_engine (
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   // Reset
   input wire logic reset,
   // Register port
   isrc_reg_if.engine bus
);
   // ----------------------------------------
   // Address stepping
   // ----------------------------------------
   function automatic logic [14:0] step_addr(input logic [14:0] a,
                                              input logic hold,
                                              input logic up);
      if (hold) begin
         return a;
      end
      return up ? a + isrc_pkg::ADDR_ONE : a - isrc_pkg::ADDR_ONE;
   endfunction

   isrc_pkg::isrc_phase_t phase;
   logic [4:0] bit_cnt;
   logic [2:0] bit_idx;
   logic [22:0] shift;
   logic is_read;
   logic [7:0] out_byte;
   wire byte_done = (phase == isrc_pkg::ST_DATA) && (bit_idx == isrc_pkg::BYTE_LAST);
   wire instr_done = (phase == isrc_pkg::ST_INSTR) && (bit_cnt == isrc_pkg::INSTR_LAST);

   assign bus.wr_en = byte_done && !is_read;
   assign bus.wdata = {shift[6:0], sdi};

   // Rising edge: shift in, decode, step the address
   always_ff @(posedge sclk or posedge reset or posedge cs_n) begin
      if (reset || cs_n) begin
         phase <= isrc_pkg::ST_INSTR;
         bit_cnt <= 5'h00;
         bit_idx <= 3'h0;
         shift <= 23'h000000;
         is_read <= 1'b0;
         bus.addr <= 15'h0000;
      end else begin
         shift <= {shift[21:0], sdi};
         case (phase)
            isrc_pkg::ST_INSTR: begin
               bit_cnt <= bit_cnt + 5'h01;
               if (instr_done) begin
                  is_read <= shift[22];
                  bus.addr <= {shift[13:0], sdi};
                  phase <= isrc_pkg::ST_DATA;
               end
            end
            isrc_pkg::ST_DATA: begin
               bit_idx <= bit_idx + 3'h1;
               if (byte_done) begin
                  bus.addr <= step_addr(bus.addr, bus.hold, bus.ascend);
               end
            end
            default: phase <= isrc_pkg::ST_INSTR;
         endcase
      end
   end

   // Falling edge: present read data, byte latched at its first bit
   always_ff @(negedge sclk or posedge reset or posedge cs_n) begin
      if (reset || cs_n) begin
         sdo <= 1'b0;
         out_byte <= 8'h00;
      end else if (phase == isrc_pkg::ST_DATA && is_read) begin
         if (bit_idx == 3'h0) begin
            out_byte <= bus.rdata;
            sdo <= bus.rdata[7];
         end else begin
            sdo <= out_byte[3'h7 - bit_idx];
         end
      end
   end
endmodule
`default_nettype wire

// ### design/isrc_config_regs.sv
// Register bank: identity codes, serial user config, timing
// reference control and edge position readback.
// Assumes a host on the serial pins and a position detector and
// timing reference receiver on the system clock.
//
// Function
// - Fixed read-only four-bit device class code
// - Fixed read-only sixteen-bit family code
// - Fixed read-only sixteen-bit maker code
// - Freeze clear: address steps by direction
// - Freeze set: address constant while streaming
// - Process reference events only when enabled
// - Power receiver only while enable set
// - Zoom bit selects finer delay steps
// - Apply delay chosen by select field
// - Direction bit: clear decrements, set increments
// - Report 24-bit reference edge position
`default_nettype none
module isrc_config_regs (
   // System clock domain
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Serial pins, link clock domain
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   // Timing reference pin
   input wire logic sync_ref_pin,
   // Position detector
   input wire logic [23:0] reference_edge_position,
   // Control to the analog and windowing logic
   output logic reference_receiver_enable,
   output logic reference_processor_enable,
   output logic window_fine_scale,
   output logic [3:0] reference_delay_select,
   output logic auto_cal_enable,
   output logic ref_event_accepted
);
   isrc_reg_if bus ();

   // ----------------------------------------
   // Serial engine
   // ----------------------------------------
   isrc_serial_engine u_engine (
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo(sdo),
      .reset(reset),
      .bus(bus)
   );

   // ----------------------------------------
   // Link-side register storage
   // ----------------------------------------
   logic [7:0] config_reg;
   logic [3:0] class_res;
   logic [7:0] user_reg;
   logic [7:0] refctl_reg;
   logic refctl_tog;
   logic [23:0] pos_link;

   // Address decode for writes and the read mux
   wire hit_config = bus.addr == isrc_pkg::OFS_CONFIG;
   wire hit_class = bus.addr == isrc_pkg::OFS_CLASS;
   wire hit_fam_lo = bus.addr == isrc_pkg::OFS_FAMILY;
   wire hit_fam_hi = bus.addr == isrc_pkg::OFS_FAMILY + isrc_pkg::ADDR_ONE;
   wire hit_mak_lo = bus.addr == isrc_pkg::OFS_MAKER;
   wire hit_mak_hi = bus.addr == isrc_pkg::OFS_MAKER + isrc_pkg::ADDR_ONE;
   wire hit_user = bus.addr == isrc_pkg::OFS_USER;
   wire hit_refctl = bus.addr == isrc_pkg::OFS_REFCTL;
   wire hit_pos0 = bus.addr == isrc_pkg::OFS_REFPOS;
   wire hit_pos1 = bus.addr == isrc_pkg::OFS_REFPOS + isrc_pkg::ADDR_ONE;
   wire hit_pos2 = bus.addr == isrc_pkg::OFS_REFPOS + isrc_pkg::ADDR_TWO;

   // Streaming direction and freeze feed the engine
   assign bus.ascend = config_reg[isrc_pkg::ASCEND_BIT];
   assign bus.hold = user_reg[isrc_pkg::HOLD_BIT];

   // Writes land on the rising serial edge of the last data bit
   always_ff @(posedge sclk or posedge reset) begin
      if (reset) begin
         config_reg <= isrc_pkg::CONFIG_RESET;
         class_res <= isrc_pkg::CLASS_RES_RESET;
         user_reg <= isrc_pkg::USER_RESET;
         refctl_reg <= isrc_pkg::REFCTL_RESET;
         refctl_tog <= 1'b0;
      end else if (bus.wr_en) begin
         if (hit_config) begin
            config_reg <= bus.wdata & isrc_pkg::CONFIG_MASK;
         end
         if (hit_class) begin
            class_res <= bus.wdata[7:4]; // Low nibble stays fixed
         end
         if (hit_user) begin
            user_reg <= bus.wdata;
         end
         if (hit_refctl) begin
            refctl_reg <= bus.wdata;
            refctl_tog <= ~refctl_tog; // Announce a new control byte
         end
      end
   end

   // Read mux; unmapped addresses read zero
   wire [7:0] rd_config = config_reg | isrc_pkg::SDO_ACTIVE_VAL;
   wire [7:0] rd_class = {class_res, isrc_pkg::CLASS_CODE};
   wire [7:0] rd_family = hit_fam_lo ? isrc_pkg::FAMILY_CODE[7:0]
                                     : isrc_pkg::FAMILY_CODE[15:8];
   wire [7:0] rd_maker = hit_mak_lo ? isrc_pkg::MAKER_CODE[7:0]
                                    : isrc_pkg::MAKER_CODE[15:8];
   wire [7:0] rd_pos = hit_pos0 ? pos_link[7:0]
                     : hit_pos1 ? pos_link[15:8]
                     : pos_link[23:16];
   assign bus.rdata = hit_config ? rd_config
                    : hit_class ? rd_class
                    : (hit_fam_lo || hit_fam_hi) ? rd_family
                    : (hit_mak_lo || hit_mak_hi) ? rd_maker
                    : hit_user ? user_reg
                    : hit_refctl ? refctl_reg
                    : (hit_pos0 || hit_pos1 || hit_pos2) ? rd_pos
                    : 8'h00;

   // ----------------------------------------
   // Control byte crossing into the system clock
   // ----------------------------------------
   // Toggle crossing: the byte is stable long before the toggle
   // arrives, since a second write needs at least a byte of clocks.
   logic tog_s1;
   logic tog_s2;
   logic tog_s3;
   logic [7:0] refctl_sys;
   wire refctl_new = tog_s2 ^ tog_s3;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
         refctl_sys <= isrc_pkg::REFCTL_RESET;
      end else if (clk_en) begin
         tog_s1 <= refctl_tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
         if (refctl_new) begin
            refctl_sys <= refctl_reg;
         end
      end
   end

   // Field outputs, all from the captured byte
   assign reference_receiver_enable = refctl_sys[isrc_pkg::RECV_EN_BIT];
   assign reference_processor_enable = refctl_sys[isrc_pkg::PROC_EN_BIT];
   assign window_fine_scale = refctl_sys[isrc_pkg::ZOOM_BIT];
   assign reference_delay_select = refctl_sys[isrc_pkg::SEL_MSB:0];

   // ----------------------------------------
   // Position snapshot crossing to the link
   // ----------------------------------------
   // Request/acknowledge loop. The link clock stops between frames,
   // so the snapshot simply waits held until the next frame acks it.
   logic [23:0] pos_snap;
   logic pos_req;
   logic ack_s1;
   logic ack_s2;
   logic pos_ack;
   logic req_s1;
   logic req_s2;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         pos_snap <= 24'h000000;
         pos_req <= 1'b0;
      end else if (clk_en) begin
         ack_s1 <= pos_ack;
         ack_s2 <= ack_s1;
         if (ack_s2 == pos_req) begin
            pos_snap <= reference_edge_position;
            pos_req <= ~pos_req;
         end
      end
   end

   // Link side takes the word once the request has settled
   always_ff @(posedge sclk or posedge reset) begin
      if (reset) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         pos_ack <= 1'b0;
         pos_link <= 24'h000000;
      end else begin
         req_s1 <= pos_req;
         req_s2 <= req_s1;
         if (req_s2 != pos_ack) begin
            pos_link <= pos_snap;
            pos_ack <= req_s2;
         end
      end
   end

   // ----------------------------------------
   // Timing reference event gating
   // ----------------------------------------
   logic ref_s1;
   logic ref_s2;
   logic ref_s3;
   wire ref_rise = ref_s2 && !ref_s3;
   // Processor without receiver sees no valid input, so gate both
   wire next_accept = ref_rise && reference_processor_enable
                      && reference_receiver_enable;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
         ref_event_accepted <= 1'b0;
         auto_cal_enable <= 1'b1;
      end else if (clk_en) begin
         ref_s1 <= sync_ref_pin;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         ref_event_accepted <= next_accept;
         auto_cal_enable <= reference_delay_select == isrc_pkg::SEL_AUTO;
      end
   end
endmodule
`default_nettype wire

// ### test/isrc_serial_host.sv
// Host model: drives serial frames into the register bank.
// Assumes sdo changes on sclk falling edges; sclk stands still between frames.
`default_nettype none
module isrc_serial_host (
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b1;
   end
   // ----------------------------------------
   // One frame: 24-bit instruction, then n bytes; byte i sits in wd[8*i+:8]
   // ----------------------------------------
   task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] rdv);
      logic [23:0] ins;
      int j;
      ins = {rd, 8'h00, a}; // Engine skips eight spare bits ahead of the address
      rdv = 32'h0;
      // Odd offset shifts the link phase against the system clock from frame to frame
      #37;
      cs_n = 1'b0;
      for (int k = 0; k < 24 + 8 * n; k++) begin
         j = 8 * ((k - 24) / 8) + 7 - (k - 24) % 8;
         if (k < 24) begin
            sdi = ins[23 - k];
         end else begin
            sdi = wd[j];
         end
         #80;
         // Read bit stands since the last falling edge
         if (k >= 24) begin
            rdv[j] = sdo;
         end
         sclk = 1'b1;
         #80;
         sclk = 1'b0;
      end
      #40;
      cs_n = 1'b1;
      // Released line shows no stale value
      sdi = ~sdi;
      #200;
   endtask
endmodule
`default_nettype wire

// ### test/isrc_config_regs_asserts.sv
// Checker: gating and timing relations at the register bank's ports.
// Assumes it is bound onto isrc_config_regs; clk_sys domain only.
`default_nettype none
module isrc_config_regs_asserts (
   // System clock domain
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo,
   // Timing reference and detector
   input wire logic sync_ref_pin,
   input wire logic [23:0] reference_edge_position,
   // Control outputs
   input wire logic reference_receiver_enable,
   input wire logic reference_processor_enable,
   input wire logic window_fine_scale,
   input wire logic [3:0] reference_delay_select,
   input wire logic auto_cal_enable,
   input wire logic ref_event_accepted
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Control byte as seen at the outputs
   wire [6:0] ctl_out;
   assign ctl_out = {reference_processor_enable, reference_receiver_enable,
                     window_fine_scale, reference_delay_select};
   a_reset_state: assert property ($fell(reset) |->
      ctl_out == 7'h00 && auto_cal_enable)
      else $error("control outputs not at reset values");
   a_autocal_tracks: assert property ($stable(reference_delay_select)[*2] |->
      auto_cal_enable == (reference_delay_select == 4'h0))
      else $error("auto calibration flag disagrees with delay select");
   // Accept pulse is registered from the enables one cycle earlier
   a_event_needs_proc: assert property (ref_event_accepted |->
      $past(reference_processor_enable))
      else $error("event accepted with processor disabled");
   a_event_needs_recv: assert property (ref_event_accepted |->
      $past(reference_receiver_enable))
      else $error("event accepted with receiver off");
   a_event_single: assert property (ref_event_accepted |=> !ref_event_accepted)
      else $error("event pulse longer than one cycle");
   a_event_latency: assert property ($rose(sync_ref_pin) &&
      reference_processor_enable && reference_receiver_enable |-> ##[1:5] ref_event_accepted)
      else $error("enabled reference edge not accepted in time");
   a_quiet_idle: assert property (cs_n [*8] |-> $stable(ctl_out))
      else $error("control outputs moved without a frame");
   a_sdo_idle: assert property (cs_n [*8] |-> !sdo)
      else $error("serial output not low while idle");
   // Main scenarios
   c_event: cover property (ref_event_accepted);
   c_manual_delay: cover property ($fell(auto_cal_enable));
   c_proc_on: cover property ($rose(reference_processor_enable));
endmodule
bind isrc_config_regs isrc_config_regs_asserts u_chk (.clk_sys(clk_sys), .reset(reset),
   .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
   .sync_ref_pin(sync_ref_pin), .reference_edge_position(reference_edge_position),
   .reference_receiver_enable(reference_receiver_enable),
   .reference_processor_enable(reference_processor_enable),
   .window_fine_scale(window_fine_scale), .reference_delay_select(reference_delay_select),
   .auto_cal_enable(auto_cal_enable), .ref_event_accepted(ref_event_accepted));
`default_nettype wire

// ### test/isrc_config_regs_tb_top.sv
// Testbench: register bank driven through the serial host model.
// Assumes the package, design, checker and host model are compiled first.
`default_nettype none
module isrc_config_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b0;
   logic clk_en = 1'b1;
   logic sync_ref_pin = 1'b0;
   logic [23:0] pos = 24'h000000;
   wire logic sclk, cs_n, sdi, sdo, recv, proc, zoom, acal, acc;
   wire logic [3:0] sel;
   int err_total = 0;
   int comparisons = 0;
   int ev_cnt = 0;
   int cyc = 0;
   logic [31:0] q;
   always #2 clk_sys = ~clk_sys;
   isrc_config_regs dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sclk(sclk),
      .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sync_ref_pin(sync_ref_pin),
      .reference_edge_position(pos), .reference_receiver_enable(recv),
      .reference_processor_enable(proc), .window_fine_scale(zoom),
      .reference_delay_select(sel), .auto_cal_enable(acal), .ref_event_accepted(acc));
   isrc_serial_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
   // Event counter and hang guard; mid-cycle sampling avoids launch-edge races
   always @(negedge clk_sys) begin
      ev_cnt += int'(acc === 1'b1);
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
      logic [31:0] junk;
      host.xfer(1'b0, a, n, d, junk);
   endtask
   task automatic pulse();
      @(posedge clk_sys);
      #1 sync_ref_pin = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 sync_ref_pin = 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_regs();
      host.xfer(1'b1, isrc_pkg::OFS_CONFIG, 1, 32'h0, q);
      chk("config", q, 32'h30);
      host.xfer(1'b1, isrc_pkg::OFS_USER, 1, 32'h0, q);
      chk("user", q, 32'h00);
      host.xfer(1'b1, isrc_pkg::OFS_REFCTL, 1, 32'h0, q);
      chk("refctl", q, 32'h00);
      host.xfer(1'b1, 15'h0040, 1, 32'h0, q);
      chk("unmapped", q, 32'h00);
      chk("auto cal", {31'h0, acal}, 32'h1);
   endtask
   task automatic t_ids();
      host.xfer(1'b1, isrc_pkg::OFS_CLASS, 3, 32'h0, q);
      chk("class family", q, {8'h0, isrc_pkg::FAMILY_CODE, 4'h0, isrc_pkg::CLASS_CODE});
      host.xfer(1'b1, isrc_pkg::OFS_MAKER, 2, 32'h0, q);
      chk("maker", q, {16'h0, isrc_pkg::MAKER_CODE});
      // Read-only bytes must ignore writes
      wr(isrc_pkg::OFS_FAMILY, 2, 32'h0000ffff);
      host.xfer(1'b1, isrc_pkg::OFS_FAMILY, 2, 32'h0, q);
      chk("family kept", q, {16'h0, isrc_pkg::FAMILY_CODE});
      // Upper class nibble is writable, the low code nibble is not
      wr(isrc_pkg::OFS_CLASS, 1, 32'hff);
      host.xfer(1'b1, isrc_pkg::OFS_CLASS, 1, 32'h0, q);
      chk("class kept", q, {24'h0, 4'hf, isrc_pkg::CLASS_CODE});
      wr(isrc_pkg::OFS_CLASS, 1, 32'h00);
   endtask
   task automatic t_descend();
      wr(isrc_pkg::OFS_CONFIG, 1, 32'h00);
      host.xfer(1'b1, 15'h0005, 3, 32'h0, q);
      chk("descend", q, {12'h0, isrc_pkg::CLASS_CODE, isrc_pkg::FAMILY_CODE[7:0],
         isrc_pkg::FAMILY_CODE[15:8]});
      wr(isrc_pkg::OFS_CONFIG, 1, 32'h20);
   endtask
   task automatic t_hold();
      wr(isrc_pkg::OFS_USER, 1, 32'h01);
      host.xfer(1'b1, isrc_pkg::OFS_FAMILY, 3, 32'h0, q);
      chk("held read", q, {8'h0, {3{isrc_pkg::FAMILY_CODE[7:0]}}});
      // Both bytes land on the control byte; the last one wins, zoom set
      wr(isrc_pkg::OFS_REFCTL, 2, 32'h3520);
      chk("ctl outputs", {25'h0, proc, recv, zoom, sel}, 32'h35);
      chk("manual delay", {31'h0, acal}, 32'h0);
      wr(isrc_pkg::OFS_USER, 1, 32'h00);
   endtask
   task automatic t_event();
      wr(isrc_pkg::OFS_REFCTL, 1, 32'h20);
      pulse();
      chk("events recv only", ev_cnt, 32'h0);
      wr(isrc_pkg::OFS_REFCTL, 1, 32'h60);
      chk("proc enable", {31'h0, proc}, 32'h1);
      chk("auto cal back", {31'h0, acal}, 32'h1);
      pulse();
      chk("events enabled", ev_cnt, 32'h1);
   endtask
   task automatic t_position();
      @(posedge clk_sys);
      #1 pos = 24'hc35a96;
      repeat (20) @(posedge clk_sys);
      host.xfer(1'b1, isrc_pkg::OFS_REFPOS, 3, 32'h0, q);
      chk("position", q, 32'h00c35a96);
   endtask
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #1 reset = 1'b1; // Rise after time zero so every async reset sees an edge
      repeat (4) @(posedge clk_sys);
      #1 reset = 1'b0;
      t_reset_regs();
      t_ids();
      t_descend();
      t_hold();
      t_event();
      t_position();
      end_sim();
   end
endmodule
`default_nettype wire
